// ==== design/sfdp_pkg.sv ====
// shared constants and carrier types for the discovery-parameter lookup slice
`default_nettype none
package sfdp_pkg;

    // ==========================================================================
    // discovery byte addresses, third parameter header
    localparam logic [23:0] HDR3_ID_LSB_ADDR  = 24'h000020;
    localparam logic [23:0] HDR3_MINOR_ADDR   = 24'h000021;
    localparam logic [23:0] HDR3_MAJOR_ADDR   = 24'h000022;
    localparam logic [23:0] HDR3_LEN_ADDR     = 24'h000023;
    localparam logic [23:0] HDR3_PTR_LO_ADDR  = 24'h000024;
    localparam logic [23:0] HDR3_PTR_HI_ADDR  = 24'h000026;
    localparam logic [23:0] HDR3_ID_MSB_ADDR  = 24'h000027;

    // ==========================================================================
    // basic flash parameter table placement
    localparam logic [23:0] BASIC_BASE_ADDR   = 24'h000080;
    localparam logic [23:0] BASIC_SLICE_BYTES = 24'h000008;  // first two double words

    // ==========================================================================
    // third header contents
    localparam logic [7:0] HDR3_MINOR_REV     = 8'h01;
    localparam logic [7:0] HDR3_MAJOR_REV     = 8'h01;
    localparam logic [7:0] HDR3_TABLE_LEN     = 8'h00;  // zero: table not implemented
    localparam logic [7:0] HDR3_PTR_BYTE      = 8'h00;

    // ==========================================================================
    // basic table byte 2 field positions
    localparam int QUAD_OUTPUT_READ_BIT      = 6;
    localparam int QUAD_IO_READ_BIT          = 5;
    localparam int DUAL_IO_READ_BIT          = 4;
    localparam int UNUSED_B2_BIT             = 7;
    localparam int SINGLE_IO_TRANSFER_BIT    = 0;

    // ==========================================================================
    // basic table contents, first two double words
    localparam logic [7:0] BASIC_B0_ERASE_FEAT = 8'he5;
    localparam logic [7:0] BASIC_B1_ERASE_4K   = 8'h20;
    localparam logic [7:0] BASIC_B2_READ_MODES = 8'((1 << UNUSED_B2_BIT)
                                                 | (1 << QUAD_OUTPUT_READ_BIT)
                                                 | (1 << QUAD_IO_READ_BIT)
                                                 | (1 << DUAL_IO_READ_BIT)
                                                 | (1 << SINGLE_IO_TRANSFER_BIT));
    localparam logic [7:0] BASIC_B3_UNUSED     = 8'hff;
    localparam logic [7:0] DENSITY_LOW_BYTE    = 8'hff;
    localparam logic [7:0] DENSITY_TOP_16M     = 8'h00;
    localparam logic [7:0] DENSITY_TOP_32M     = 8'h01;
    localparam logic [7:0] DENSITY_TOP_64M     = 8'h03;
    localparam logic [7:0] UNMAPPED_BYTE       = 8'hff;

    // ==========================================================================
    // carrier and state types
    typedef struct packed {
        logic        cs_b;   // chip select, active low
        logic        start;  // address phase complete, addr valid
        logic        shift;  // one serial bit clock consumed
        logic [23:0] addr;   // starting discovery byte address
    } link_req_t;

    typedef enum logic {IDLE, SHIFT} xfer_state_t;

    typedef struct packed {
        xfer_state_t state;
        logic [23:0] addr;
        logic [7:0]  shreg;
        logic [2:0]  bitcnt;
    } xfer_t;

endpackage : sfdp_pkg
`default_nettype wire

// ==== design/sfdp_rom.sv ====
// constant lookup of discovery bytes in the implemented address slice
`timescale 1ns/1ps
`default_nettype none

module sfdp_rom #(
    parameter int         DENSITY_MBIT = 16,     // 16, 32 or 64
    parameter logic [7:0] VENDOR_ID    = 8'h5a,  // arbitrary value
    parameter logic [7:0] VENDOR_BANK  = 8'h3c   // arbitrary value
) (
    input  wire logic [23:0] addr_i,  // discovery byte address
    output logic      [7:0]  data_o   // byte stored there
);

    // ==========================================================================
    // elaboration check
    if (!(DENSITY_MBIT == 16 || DENSITY_MBIT == 32 || DENSITY_MBIT == 64)) begin : g_bad
        $error("density must be 16, 32 or 64 Mbit");
    end

    // top density byte per variant
    function automatic logic [7:0] density_top(input int mbit);
        case (mbit)
            16:      density_top = sfdp_pkg::DENSITY_TOP_16M;
            32:      density_top = sfdp_pkg::DENSITY_TOP_32M;
            default: density_top = sfdp_pkg::DENSITY_TOP_64M;
        endcase
    endfunction : density_top

    logic [23:0] rel;

    // ==========================================================================
    // lookup; anything outside this slice reads as erased flash
    always_comb begin
        rel    = addr_i - sfdp_pkg::BASIC_BASE_ADDR;
        data_o = sfdp_pkg::UNMAPPED_BYTE;
        if (addr_i == sfdp_pkg::HDR3_ID_LSB_ADDR) begin
            data_o = VENDOR_ID;
        end else if (addr_i == sfdp_pkg::HDR3_MINOR_ADDR) begin
            data_o = sfdp_pkg::HDR3_MINOR_REV;
        end else if (addr_i == sfdp_pkg::HDR3_MAJOR_ADDR) begin
            data_o = sfdp_pkg::HDR3_MAJOR_REV;
        end else if (addr_i == sfdp_pkg::HDR3_LEN_ADDR) begin
            data_o = sfdp_pkg::HDR3_TABLE_LEN;
        end else if (addr_i >= sfdp_pkg::HDR3_PTR_LO_ADDR
                     && addr_i <= sfdp_pkg::HDR3_PTR_HI_ADDR) begin
            data_o = sfdp_pkg::HDR3_PTR_BYTE;
        end else if (addr_i == sfdp_pkg::HDR3_ID_MSB_ADDR) begin
            data_o = VENDOR_BANK;
        end else if (addr_i >= sfdp_pkg::BASIC_BASE_ADDR
                     && rel < sfdp_pkg::BASIC_SLICE_BYTES) begin
            case (rel[2:0])
                3'h0:    data_o = sfdp_pkg::BASIC_B0_ERASE_FEAT;
                3'h1:    data_o = sfdp_pkg::BASIC_B1_ERASE_4K;
                3'h2:    data_o = sfdp_pkg::BASIC_B2_READ_MODES;
                3'h3:    data_o = sfdp_pkg::BASIC_B3_UNUSED;
                3'h7:    data_o = density_top(DENSITY_MBIT);
                default: data_o = sfdp_pkg::DENSITY_LOW_BYTE;
            endcase
        end
    end

endmodule : sfdp_rom

`default_nettype wire

// ==== design/sfdp_reader.sv ====
// serial byte streamer for the discovery-parameter lookup slice
//
// the command framing (opcode, address, dummy bits) lives outside this block;
// it signals the end of the address phase with a one-cycle start pulse and
// then sends one shift pulse per serial bit that the host has consumed.
// the block answers with the addressed byte, msb first, and keeps walking
// upward through the discovery space for as long as chip select stays low.
// there is no bit clock pin here: bits are counted on shift pulses, so a
// slow host may leave any number of idle cycles between two bits.
// limitation: only the third parameter header and the first two basic
// double words are mapped; every other address reads as erased flash.
// the density variant is fixed at elaboration; it is not a run-time mode.
// the address counter wraps at 24 bits, as the three-byte address space does;
// a start while a byte is half sent drops the rest of that byte.
//
// Operation
// - byte 20h returns the vendor identification code, low part of the id
// - bytes 21h and 22h return minor and major revision one
// - byte 23h returns table length zero: third table absent
// - bytes 24h to 26h return zero pointer bytes
// - byte 27h returns the vendor bank number, high part of the id
// - basic table byte zero returns e5h erase and status features
// - basic table byte one returns 4 kB erase opcode 20h
// - basic table byte two returns f1h read mode support flags
// - basic table byte three returns ffh
// - basic bytes four to seven give zero-based density, little-endian
// - basic table relative bytes sit from discovery address 80h upward
`timescale 1ns/1ps
`default_nettype none

module sfdp_reader #(
    parameter int         DENSITY_MBIT = 16,     // 16, 32 or 64
    parameter logic [7:0] VENDOR_ID    = 8'h5a,  // arbitrary value
    parameter logic [7:0] VENDOR_BANK  = 8'h3c   // arbitrary value
) (
    input  wire logic                 clock_i,  // 100 MHz system clock
    input  wire logic                 rst_b_i,  // async reset, active low
    input  wire sfdp_pkg::link_req_t  req_i,    // framing requests
    output logic                      so_o,     // serial data out, msb first
    output logic                      valid_o   // so_o carries a live bit
);

    sfdp_pkg::xfer_t st_r;
    sfdp_pkg::xfer_t st_nxt;
    logic [23:0]     rom_addr;
    logic [7:0]      rom_data;

    // ==========================================================================
    // elaboration check; the lookup only knows three density variants
    if (!(DENSITY_MBIT == 16 || DENSITY_MBIT == 32 || DENSITY_MBIT == 64)) begin : g_bad_density
        $error("reader density must be 16, 32 or 64 Mbit");
    end

    // ==========================================================================
    // lookup: the start address on a load, else the byte after the current one;
    // looking ahead all the time lets the next msb follow bit 0 with no gap,
    // at the cost of a 24-bit incrementer in front of the lookup
    assign rom_addr = req_i.start ? req_i.addr : st_r.addr + 24'h000001;

    sfdp_rom #(
        .DENSITY_MBIT (DENSITY_MBIT),
        .VENDOR_ID    (VENDOR_ID),
        .VENDOR_BANK  (VENDOR_BANK)
    ) u_rom (
        .addr_i (rom_addr),
        .data_o (rom_data)
    );

    // ==========================================================================
    // next state; chip select high aborts at once, even mid-byte
    always_comb begin
        st_nxt = st_r;
        // deselect wins over everything; a partial byte is simply dropped
        if (req_i.cs_b) begin
            st_nxt.state  = sfdp_pkg::IDLE;
            st_nxt.bitcnt = 3'h0;
        end else if (req_i.start) begin
            // a start while streaming restarts at the new address
            st_nxt.state  = sfdp_pkg::SHIFT;
            st_nxt.addr   = req_i.addr;
            st_nxt.shreg  = rom_data;
            st_nxt.bitcnt = 3'h7;
        end else begin
            case (st_r.state)
                sfdp_pkg::SHIFT: begin
                    if (req_i.shift) begin
                        if (st_r.bitcnt == 3'h0) begin
                            // fetch ahead so the next msb appears with no gap
                            st_nxt.addr   = st_r.addr + 24'h000001;
                            st_nxt.shreg  = rom_data;
                            st_nxt.bitcnt = 3'h7;
                        end else begin
                            st_nxt.shreg  = {st_r.shreg[6:0], 1'b0};
                            st_nxt.bitcnt = st_r.bitcnt - 3'h1;
                        end
                    end
                end
                sfdp_pkg::IDLE: begin
                    // shift pulses are ignored until a start has loaded a byte
                    st_nxt.state = sfdp_pkg::IDLE;
                end
                default: st_nxt.state = sfdp_pkg::IDLE;
            endcase
        end
    end

    // state register; the reset value only has to keep the outputs quiet,
    // the address and shift contents are reloaded by every start
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '{state: sfdp_pkg::IDLE, addr: 24'h000000, shreg: 8'h00, bitcnt: 3'h0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // decoded for both outputs, so kept in one place
    function automatic logic is_live(input sfdp_pkg::xfer_state_t s);
        is_live = (s == sfdp_pkg::SHIFT);
    endfunction : is_live

    // outputs straight from flops through one gate; the shift register is not
    // cleared on deselect, so the gate is what keeps the data line quiet
    assign so_o    = is_live(st_r.state) ? st_r.shreg[7] : 1'b0;
    assign valid_o = is_live(st_r.state);

    // ==========================================================================
    // assertions
    // the lookup checks watch the rom port on every cycle, so they fire for a
    // start address and for every fetch-ahead alike; the stream checks follow
    // one transfer edge by edge
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    // third parameter header
    a_vendor_id_lsb: assert property (rom_addr == 24'h000020 |-> rom_data == VENDOR_ID)
        else $error("vendor id low byte wrong");
    a_hdr3_revision: assert property (
        (rom_addr == 24'h000021 || rom_addr == 24'h000022) |-> rom_data == 8'h01)
        else $error("third header revision wrong");
    a_hdr3_length: assert property (rom_addr == 24'h000023 |-> rom_data == 8'h00)
        else $error("third header length not zero");
    a_hdr3_pointer: assert property (
        rom_addr inside {24'h000024, 24'h000025, 24'h000026} |-> rom_data == 8'h00)
        else $error("third header pointer not zero");
    a_vendor_bank_msb: assert property (rom_addr == 24'h000027 |-> rom_data == VENDOR_BANK)
        else $error("vendor bank byte wrong");
    a_header_end: assert property (rom_addr == 24'h000028 |-> rom_data == 8'hff)
        else $error("byte past the third header not erased");

    // basic table, first two double words
    a_basic_byte_zero: assert property (
        !req_i.cs_b && req_i.start && req_i.addr == 24'h000080
        |=> valid_o && so_o && st_r.shreg == 8'he5)
        else $error("basic byte zero not loaded as e5h");
    a_erase_features: assert property (rom_addr == 24'h000080 |-> rom_data == 8'he5)
        else $error("erase feature byte wrong");
    a_erase_opcode: assert property (rom_addr == 24'h000081 |-> rom_data == 8'h20)
        else $error("erase opcode wrong");
    a_read_modes: assert property (rom_addr == 24'h000082 |-> rom_data == 8'hf1)
        else $error("read mode byte wrong");
    a_dword_top: assert property (rom_addr == 24'h000083 |-> rom_data == 8'hff)
        else $error("first dword top byte wrong");
    a_density_low: assert property (
        rom_addr inside {24'h000084, 24'h000085, 24'h000086} |-> rom_data == 8'hff)
        else $error("density low bytes wrong");
    a_density_word: assert property (
        rom_addr == 24'h000087
        |-> rom_data == (DENSITY_MBIT == 16 ? 8'h00 : DENSITY_MBIT == 32 ? 8'h01 : 8'h03))
        else $error("density top byte wrong");
    a_base_offset: assert property (rom_addr == 24'h00007f |-> rom_data == 8'hff)
        else $error("basic table does not start at 80h");
    a_slice_end: assert property (rom_addr == 24'h000088 |-> rom_data == 8'hff)
        else $error("byte past the mapped basic slice not erased");

    // serial stream
    a_start_load: assert property (
        !req_i.cs_b && req_i.start
        |=> valid_o && st_r.addr == $past(req_i.addr) && st_r.bitcnt == 3'h7)
        else $error("start did not load the addressed byte");
    a_first_bit: assert property (
        !req_i.cs_b && req_i.start
        |=> so_o == $past(rom_data[7]))
        else $error("first bit after start is not the msb");
    a_restart_mid: assert property (
        !req_i.cs_b && req_i.start && valid_o && st_r.bitcnt != 3'h7
        |=> st_r.bitcnt == 3'h7 && st_r.addr == $past(req_i.addr))
        else $error("start while streaming did not restart");
    a_byte_advance: assert property (
        !req_i.cs_b && !req_i.start && valid_o && req_i.shift && st_r.bitcnt == 3'h0
        |=> st_r.addr == $past(st_r.addr) + 24'h000001 && st_r.shreg == $past(rom_data))
        else $error("next byte not fetched in order");
    a_msb_order: assert property (
        !req_i.cs_b && !req_i.start && valid_o && req_i.shift && st_r.bitcnt != 3'h0
        |=> so_o == $past(st_r.shreg[6]))
        else $error("bits not shifted msb first");
    a_bit_count: assert property (
        !req_i.cs_b && !req_i.start && valid_o && req_i.shift
        |=> st_r.bitcnt == 3'($past(st_r.bitcnt) - 3'h1))
        else $error("byte is not eight shift pulses long");
    a_hold_no_shift: assert property (
        !req_i.cs_b && !req_i.start && valid_o && !req_i.shift
        |=> valid_o && $stable(st_r.shreg) && $stable(st_r.bitcnt))
        else $error("stream moved without a shift pulse");
    a_deselect_idle: assert property (req_i.cs_b |=> !valid_o && !so_o)
        else $error("output live after deselect");
    a_deselect_drop: assert property (req_i.cs_b |=> st_r.bitcnt == 3'h0)
        else $error("partial byte kept across deselect");
    a_reset_quiet: assert property (disable iff (1'b0) !rst_b_i |-> !valid_o && !so_o)
        else $error("output live during reset");

    // main scenarios
    c_read_vendor: cover property (req_i.start && !req_i.cs_b && req_i.addr == 24'h000020);
    c_byte_cross: cover property (valid_o && req_i.shift && st_r.bitcnt == 3'h0 && !req_i.cs_b);
    c_abort_mid: cover property (valid_o && st_r.bitcnt == 3'h3 ##1 req_i.cs_b);
    c_slow_host: cover property (valid_o && !req_i.shift ##1 valid_o && req_i.shift);
    c_density_top: cover property (valid_o && rom_addr == 24'h000087);

endmodule : sfdp_reader

`default_nettype wire

// ==== tb/sfdp_host_model.sv ====
// host model that frames discovery reads and gathers the returned bytes
`timescale 1ns/1ps
`default_nettype none

module sfdp_host_model (
    input  wire logic                clock_i,  // bench clock
    input  wire logic                so_i,     // serial data from device
    input  wire logic                valid_i,  // device marks a live bit
    output var  sfdp_pkg::link_req_t req_o     // framing toward device
);
    logic [7:0] got [16];  // bytes gathered by the last read
    int         stray;     // bit clocks that found no live bit

    // ==========================================================================
    // idle: deselected, address lines hold a pattern rather than a stale value
    initial begin
        req_o = '{cs_b: 1'b1, start: 1'b0, shift: 1'b0, addr: 24'h5a5a5a};
        stray = 0;
    end

    // one framed read of nbits bits; gap idle cycles per bit model a slow host
    task automatic read_bits(input logic [23:0] a, input int nbits, input int gap,
                             input bit keep);
        for (int i = 0; i < 16; i++) got[i] = 8'h00;
        @(posedge clock_i);
        req_o.cs_b  <= 1'b0;
        req_o.start <= 1'b1;
        req_o.addr  <= a;
        @(posedge clock_i);
        req_o.start <= 1'b0;
        req_o.addr  <= ~a;  // address means nothing once start has passed
        for (int i = 0; i < nbits; i++) begin
            if (gap > 0) begin
                req_o.shift <= 1'b0;
                repeat (gap) @(posedge clock_i);
            end
            req_o.shift <= 1'b1;
            @(posedge clock_i);
            if (valid_i !== 1'b1) stray++;
            got[i/8] = {got[i/8][6:0], so_i};
        end
        req_o.shift <= 1'b0;
        if (!keep) req_o.cs_b <= 1'b1;
    endtask : read_bits

endmodule : sfdp_host_model
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the discovery-parameter byte streamer
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam int         DENS = 64;
    localparam logic [7:0] VID  = 8'h5a;  // arbitrary value
    localparam logic [7:0] VBNK = 8'h3c;  // arbitrary value

    logic                clock_i;     // bench clock
    logic                rst_b_i;     // reset, active low
    sfdp_pkg::link_req_t req;         // host framing
    logic                so;          // serial data
    logic                valid;       // live bit flag
    int                  failures;    // mismatches
    int                  n_compared;  // comparisons

    sfdp_reader #(.DENSITY_MBIT(DENS), .VENDOR_ID(VID), .VENDOR_BANK(VBNK)) DUT (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .req_i(req), .so_o(so), .valid_o(valid));

    sfdp_host_model HOST (.clock_i(clock_i), .so_i(so), .valid_i(valid), .req_o(req));

    // ==========================================================================
    // compare and verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    // third header in one unbroken stream, then deselect
    task automatic t_header3();
        HOST.read_bits(24'h000020, 64, 0, 0);
        chk(HOST.got[0], VID);
        chk(HOST.got[1], 8'h01);
        chk(HOST.got[2], 8'h01);
        chk(HOST.got[3], 8'h00);
        chk(HOST.got[4], 8'h00);
        chk(HOST.got[5], 8'h00);
        chk(HOST.got[6], 8'h00);
        chk(HOST.got[7], VBNK);
        chk(8'(HOST.stray), 8'h00);
        repeat (2) @(posedge clock_i);
        chk({6'h00, valid, so}, 8'h00);
    endtask : t_header3

    // stream across the unmapped byte just below the basic table into it
    task automatic t_basic();
        HOST.read_bits(24'h00007f, 72, 0, 0);
        chk(HOST.got[0], 8'hff);
        chk(HOST.got[1], 8'he5);
        chk(HOST.got[2], 8'h20);
        chk(HOST.got[3], 8'hf1);
        chk(HOST.got[4], 8'hff);
        chk(HOST.got[5], 8'hff);
        chk(HOST.got[6], 8'hff);
        chk(HOST.got[7], 8'hff);
        chk(HOST.got[8], 8'h03);
    endtask : t_basic

    // partial byte abandoned by a fresh start, then a slow host with gaps
    task automatic t_restart();
        HOST.read_bits(24'h000080, 3, 0, 1);
        chk(HOST.got[0], 8'h07);
        HOST.read_bits(24'h000026, 24, 2, 0);
        chk(HOST.got[0], 8'h00);
        chk(HOST.got[1], VBNK);
        chk(HOST.got[2], 8'hff);
        chk(8'(HOST.stray), 8'h00);
    endtask : t_restart

    // ==========================================================================
    // clock, main sequence and watchdog
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    initial begin
        failures   = 0;
        n_compared = 0;
        rst_b_i    = 1'b0;
        repeat (4) @(posedge clock_i);
        chk({6'h00, valid, so}, 8'h00);
        rst_b_i <= 1'b1;
        t_header3();
        t_basic();
        t_restart();
        end_sim();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #20000;
        failures++;
        end_sim();
    end

endmodule : tb
`default_nettype wire
